// file: design/ehcic_pkg.sv
package ehcic_pkg;
    // Register byte offset from the operational base
    localparam logic [7:0] USB_COMMAND_OFFSET = 8'h20;
    // Field positions
    localparam int THRESHOLD_LSB = 16;
    localparam int LIGHT_RESET_BIT = 7;
    localparam int DOORBELL_BIT = 6;
    localparam int ASYNC_ENABLE_BIT = 5;
    localparam int PERIODIC_ENABLE_BIT = 4;
    // Reset values
    localparam logic [7:0] THRESHOLD_RESET = 8'h08;
    localparam logic [31:0] USB_COMMAND_RESET = 32'h0008_0000;
    // Threshold codes in microframes
    localparam logic [7:0] THRESHOLD_RESERVED = 8'h00;
    localparam logic [7:0] THRESHOLD_MAX = 8'h40;
    // Microframe is 125 us; cycles at 25 MHz
    localparam int MICROFRAME_NS = 125000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int MICROFRAME_CYCLES = MICROFRAME_NS / CLK_PERIOD_NS;
    // Light reset and cache eviction durations in cycles
    localparam logic [7:0] LIGHT_RESET_CYCLES = 8'h10;
    localparam logic [7:0] EVICT_CYCLES = 8'h04;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } ehcic_req_t;

    typedef enum logic [1:0] {
        EHCIC_IDLE = 2'b00,
        EHCIC_EVICT = 2'b01,
        EHCIC_WAIT_BOUNDARY = 2'b10
    } ehcic_door_state_t;
endpackage

// file: design/ehcic_command.sv
`timescale 1ns/1ps
// What this block does
// - Interrupt threshold field defaults to 8; codes 1,2,4,8,16,32; zero reserved.
// - Threshold code 40h (64 microframes, 8 ms) is also accepted.
// - If light reset were absent its bit would read zero.
// - Light reset resets the core but not ports or companion hand-off.
// - Light reset bit reads one while in progress, zero when done.
// - After doorbell, evict cached state, then set async advance status.
// - Status set raises interrupt at next threshold boundary if enabled.
// - Async schedule enable resets zero; one fetches from async list address.
// - Periodic schedule enable resets zero; one fetches from periodic list base.
module ehcic_command (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire ehcic_pkg::ehcic_req_t req_i,
    input wire logic controller_halted_flag_i,
    input wire logic async_advance_int_enable_i,
    input wire logic async_advance_status_clear_i,
    output logic [31:0] rdata_o,
    output logic async_advance_status_o,
    output logic async_advance_irq_o,
    output logic async_schedule_enable_o,
    output logic periodic_schedule_enable_o,
    output logic core_reset_o,
    output logic evict_cache_o
);
    logic [7:0] interrupt_threshold_reg;
    logic light_reset_reg;
    logic [7:0] light_count_reg;
    logic doorbell_reg;
    logic async_en_reg;
    logic periodic_en_reg;
    logic [3:0] low_bits_reg;
    logic status_reg;
    logic irq_reg;
    logic [12:0] uframe_count_reg;
    logic [7:0] uframe_tick_reg;
    logic [7:0] evict_count_reg;
    logic boundary;
    logic cmd_write;
    ehcic_pkg::ehcic_door_state_t door_state_reg;

    function automatic logic threshold_valid(input logic [7:0] code);
        threshold_valid = (code != ehcic_pkg::THRESHOLD_RESERVED)
            && ((code & (code - 8'h01)) == 8'h00)
            && (code <= ehcic_pkg::THRESHOLD_MAX);
    endfunction

    assign cmd_write = req_i.write && (req_i.addr == ehcic_pkg::USB_COMMAND_OFFSET);

    // Threshold written only while halted; invalid codes are refused
    always_ff @(posedge clk_i)
    begin
        if (reset_i || light_reset_reg)
        begin
            interrupt_threshold_reg <= ehcic_pkg::THRESHOLD_RESET;
        end
        else if (cmd_write && controller_halted_flag_i
            && threshold_valid(req_i.wdata[ehcic_pkg::THRESHOLD_LSB +: 8]))
        begin
            interrupt_threshold_reg <= req_i.wdata[ehcic_pkg::THRESHOLD_LSB +: 8];
        end
    end

    // Schedule enables and the remaining low command bits
    always_ff @(posedge clk_i)
    begin
        if (reset_i || light_reset_reg)
        begin
            async_en_reg <= 1'b0;
            periodic_en_reg <= 1'b0;
            low_bits_reg <= 4'h0;
        end
        else if (cmd_write)
        begin
            async_en_reg <= req_i.wdata[ehcic_pkg::ASYNC_ENABLE_BIT];
            periodic_en_reg <= req_i.wdata[ehcic_pkg::PERIODIC_ENABLE_BIT];
            low_bits_reg <= req_i.wdata[3:0];
        end
    end

    // Light reset: core only, port state lives outside this block
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            light_reset_reg <= 1'b0;
            light_count_reg <= 8'h00;
        end
        else if (light_reset_reg)
        begin
            light_count_reg <= light_count_reg - 8'h01;
            if (light_count_reg == 8'h01)
            begin
                light_reset_reg <= 1'b0;
            end
        end
        else if (cmd_write && req_i.wdata[ehcic_pkg::LIGHT_RESET_BIT])
        begin
            light_reset_reg <= 1'b1;
            light_count_reg <= ehcic_pkg::LIGHT_RESET_CYCLES;
        end
    end

    // Microframe and threshold boundary timing
    always_ff @(posedge clk_i)
    begin
        if (reset_i || light_reset_reg)
        begin
            uframe_count_reg <= 13'h0000;
            uframe_tick_reg <= 8'h00;
        end
        else if (uframe_count_reg == 13'(ehcic_pkg::MICROFRAME_CYCLES - 1))
        begin
            uframe_count_reg <= 13'h0000;
            if (uframe_tick_reg >= interrupt_threshold_reg - 8'h01)
            begin
                uframe_tick_reg <= 8'h00;
            end
            else
            begin
                uframe_tick_reg <= uframe_tick_reg + 8'h01;
            end
        end
        else
        begin
            uframe_count_reg <= uframe_count_reg + 13'h0001;
        end
    end

    assign boundary = (uframe_count_reg == 13'(ehcic_pkg::MICROFRAME_CYCLES - 1))
        && (uframe_tick_reg >= interrupt_threshold_reg - 8'h01);

    // Doorbell sequence: evict, then set status
    always_ff @(posedge clk_i)
    begin
        if (reset_i || light_reset_reg)
        begin
            door_state_reg <= ehcic_pkg::EHCIC_IDLE;
            doorbell_reg <= 1'b0;
            evict_count_reg <= 8'h00;
        end
        else
        begin
            unique case (door_state_reg)
                ehcic_pkg::EHCIC_IDLE:
                begin
                    if (cmd_write && req_i.wdata[ehcic_pkg::DOORBELL_BIT])
                    begin
                        doorbell_reg <= 1'b1;
                        evict_count_reg <= ehcic_pkg::EVICT_CYCLES;
                        door_state_reg <= ehcic_pkg::EHCIC_EVICT;
                    end
                end
                ehcic_pkg::EHCIC_EVICT:
                begin
                    evict_count_reg <= evict_count_reg - 8'h01;
                    if (evict_count_reg == 8'h01)
                    begin
                        doorbell_reg <= 1'b0;
                        door_state_reg <= ehcic_pkg::EHCIC_WAIT_BOUNDARY;
                    end
                end
                ehcic_pkg::EHCIC_WAIT_BOUNDARY:
                begin
                    door_state_reg <= ehcic_pkg::EHCIC_IDLE;
                end
                default:
                begin
                    door_state_reg <= ehcic_pkg::EHCIC_IDLE;
                end
            endcase
        end
    end

    // Status flag: set wins over clear
    always_ff @(posedge clk_i)
    begin
        if (reset_i || light_reset_reg)
        begin
            status_reg <= 1'b0;
        end
        else if (door_state_reg == ehcic_pkg::EHCIC_WAIT_BOUNDARY)
        begin
            status_reg <= 1'b1;
        end
        else if (async_advance_status_clear_i)
        begin
            status_reg <= 1'b0;
        end
    end

    // Interrupt at threshold boundary while status set and enabled
    always_ff @(posedge clk_i)
    begin
        if (reset_i || light_reset_reg)
        begin
            irq_reg <= 1'b0;
        end
        else if (!status_reg || !async_advance_int_enable_i)
        begin
            irq_reg <= 1'b0;
        end
        else if (boundary)
        begin
            irq_reg <= 1'b1;
        end
    end

    // Read data; reserved bits read zero
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            rdata_o <= ehcic_pkg::USB_COMMAND_RESET;
        end
        else if (req_i.read && req_i.addr == ehcic_pkg::USB_COMMAND_OFFSET)
        begin
            rdata_o <= {8'h00, interrupt_threshold_reg, 8'h00,
                light_reset_reg, doorbell_reg, async_en_reg,
                periodic_en_reg, low_bits_reg};
        end
        else
        begin
            rdata_o <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            async_advance_status_o <= 1'b0;
            async_advance_irq_o <= 1'b0;
            async_schedule_enable_o <= 1'b0;
            periodic_schedule_enable_o <= 1'b0;
            core_reset_o <= 1'b0;
            evict_cache_o <= 1'b0;
        end
        else
        begin
            async_advance_status_o <= status_reg;
            async_advance_irq_o <= irq_reg;
            async_schedule_enable_o <= async_en_reg;
            periodic_schedule_enable_o <= periodic_en_reg;
            core_reset_o <= light_reset_reg;
            evict_cache_o <= (door_state_reg == ehcic_pkg::EHCIC_EVICT);
        end
    end
endmodule

// file: bench/ehcic_command_props.sv
`timescale 1ns/1ps
module ehcic_command_props (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire ehcic_pkg::ehcic_req_t req_i,
    input wire logic async_advance_int_enable_i,
    input wire logic [31:0] rdata_o,
    input wire logic async_advance_status_o,
    input wire logic async_advance_irq_o,
    input wire logic async_schedule_enable_o,
    input wire logic periodic_schedule_enable_o,
    input wire logic core_reset_o,
    input wire logic evict_cache_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic wr_cmd;
    logic light_start_reg;
    logic [7:0] threshold;
    // A light reset write blanks the next cycle before the core reset output shows it
    always_ff @(posedge clk_i)
    begin
        light_start_reg <= req_i.write && req_i.addr == ehcic_pkg::USB_COMMAND_OFFSET
            && req_i.wdata[ehcic_pkg::LIGHT_RESET_BIT];
    end
    // Plain command writes, outside a light reset
    assign wr_cmd = req_i.write && req_i.addr == ehcic_pkg::USB_COMMAND_OFFSET && !core_reset_o
        && !light_start_reg && !req_i.wdata[ehcic_pkg::LIGHT_RESET_BIT];
    assign threshold = rdata_o[ehcic_pkg::THRESHOLD_LSB +: 8];
    a_rdata_idle_zero: assert property (!$past(req_i.read) && !$past(reset_i)
        |-> rdata_o == '0)
        else $error("read data not zero while idle");
    a_reserved_bits_zero: assert property (rdata_o[15:8] == 8'h00)
        else $error("reserved command bits read nonzero");
    a_threshold_code_valid: assert property ($past(req_i.read)
        && $past(req_i.addr) == ehcic_pkg::USB_COMMAND_OFFSET
        |-> $onehot(threshold) && threshold <= ehcic_pkg::THRESHOLD_MAX)
        else $error("threshold reads an invalid code");
    a_light_reset_hold: assert property ($rose(core_reset_o)
        |-> core_reset_o [*8])
        else $error("light reset too short");
    a_light_reset_end: assert property ($rose(core_reset_o)
        |-> ##[1:40] !core_reset_o)
        else $error("light reset never ends");
    a_evict_span: assert property ($rose(evict_cache_o)
        |-> evict_cache_o [*4] ##1 !evict_cache_o)
        else $error("eviction span wrong");
    a_status_after_evict: assert property ($fell(evict_cache_o)
        |-> ##[1:3] async_advance_status_o)
        else $error("status not set after eviction");
    a_irq_needs_enable: assert property (async_advance_irq_o
        |-> $past(async_advance_int_enable_i, 2))
        else $error("interrupt raised while disabled");
    a_async_enable_write: assert property (wr_cmd
        |-> ##2 async_schedule_enable_o
            == $past(req_i.wdata[ehcic_pkg::ASYNC_ENABLE_BIT], 2))
        else $error("async enable does not follow write");
    a_periodic_enable_write: assert property (wr_cmd
        |-> ##2 periodic_schedule_enable_o
            == $past(req_i.wdata[ehcic_pkg::PERIODIC_ENABLE_BIT], 2))
        else $error("periodic enable does not follow write");
    c_doorbell: cover property ($rose(async_advance_status_o));
    c_irq: cover property ($rose(async_advance_irq_o));
    c_light_reset: cover property ($rose(core_reset_o));
endmodule
bind ehcic_command ehcic_command_props u_props (.clk_i(clk_i), .reset_i(reset_i), .req_i(req_i),
    .async_advance_int_enable_i(async_advance_int_enable_i), .rdata_o(rdata_o),
    .async_advance_status_o(async_advance_status_o), .async_advance_irq_o(async_advance_irq_o),
    .async_schedule_enable_o(async_schedule_enable_o), .core_reset_o(core_reset_o),
    .periodic_schedule_enable_o(periodic_schedule_enable_o), .evict_cache_o(evict_cache_o));

// file: bench/ehcic_command_tb.sv
`timescale 1ns/1ps
module ehcic_command_tb;
    typedef struct packed {
        logic halted;
        logic [31:0] wdata;
        logic [31:0] rexp;
    } ehcic_row_t;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    ehcic_pkg::ehcic_req_t req_i = '0;
    logic halted_i = 1'b1;
    logic enable_i = 1'b1;
    logic clear_i = 1'b0;
    logic [31:0] rdata_o;
    logic status_o, irq_o, async_en_o, periodic_en_o, core_o, evict_o;
    int n_fail = 0;
    int compares = 0;
    int k;
    // Threshold codes, two refused codes, a write while running, reserved bits
    ehcic_row_t rows [12] = '{
        '{1'b1, 32'h0001_0030, 32'h0001_0030}, '{1'b1, 32'h0002_0000, 32'h0002_0000},
        '{1'b1, 32'h0004_0010, 32'h0004_0010}, '{1'b1, 32'h0008_0000, 32'h0008_0000},
        '{1'b1, 32'h0010_0000, 32'h0010_0000}, '{1'b1, 32'h0020_0000, 32'h0020_0000},
        '{1'b1, 32'h0040_0000, 32'h0040_0000}, '{1'b1, 32'h0000_0000, 32'h0040_0000},
        '{1'b1, 32'h0003_0000, 32'h0040_0000}, '{1'b0, 32'h0008_0000, 32'h0040_0000},
        '{1'b1, 32'hff01_ff2f, 32'h0001_002f}, '{1'b1, 32'h0001_0020, 32'h0001_0020}};
    ehcic_command DUT (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .req_i(req_i),
        .controller_halted_flag_i(halted_i),
        .async_advance_int_enable_i(enable_i),
        .async_advance_status_clear_i(clear_i),
        .rdata_o(rdata_o),
        .async_advance_status_o(status_o),
        .async_advance_irq_o(irq_o),
        .async_schedule_enable_o(async_en_o),
        .periodic_schedule_enable_o(periodic_en_o),
        .core_reset_o(core_o),
        .evict_cache_o(evict_o)
    );
    initial
    begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] d);
        req_i.write = 1'b1;
        req_i.addr = ehcic_pkg::USB_COMMAND_OFFSET;
        req_i.wdata = d;
        @(negedge clk_i);
        req_i.write = 1'b0;
    endtask
    task automatic rd_chk(input logic [31:0] exp);
        req_i.read = 1'b1;
        req_i.addr = ehcic_pkg::USB_COMMAND_OFFSET;
        @(negedge clk_i);
        req_i.read = 1'b0;
        chk(rdata_o, exp);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic ring();
        logic seen;
        seen = 1'b0;
        wr(32'h0001_0060);
        for (k = 0; k < 20 && status_o !== 1'b1; k++)
        begin
            seen = seen | evict_o;
            @(negedge clk_i);
        end
        chk({31'h0, seen}, 32'h1);
    endtask
    initial
    begin
        repeat (12) @(negedge clk_i);
        reset_i = 1'b0;
        rd_chk(32'h0008_0000);
        for (int i = 0; i < 12; i++)
        begin
            halted_i = rows[i].halted;
            wr(rows[i].wdata);
            @(negedge clk_i);
            chk({30'h0, async_en_o, periodic_en_o},
                {30'h0, rows[i].rexp[5:4]});
            rd_chk(rows[i].rexp);
        end
        halted_i = 1'b1;
        ring();
        chk({31'h0, status_o}, 32'h1);
        for (k = 0; k < ehcic_pkg::MICROFRAME_CYCLES + 100 && irq_o !== 1'b1; k++)
        begin
            @(negedge clk_i);
        end
        chk({31'h0, irq_o}, 32'h1);
        clear_i = 1'b1;
        @(negedge clk_i);
        clear_i = 1'b0;
        repeat (3) @(negedge clk_i);
        chk({30'h0, status_o, irq_o}, 32'h0);
        enable_i = 1'b0;
        ring();
        repeat (ehcic_pkg::MICROFRAME_CYCLES + 100) @(negedge clk_i);
        chk({30'h0, status_o, irq_o}, 32'h2);
        wr(32'h0000_0080);
        req_i.read = 1'b1;
        @(negedge clk_i);
        req_i.read = 1'b0;
        chk({30'h0, rdata_o[7], core_o}, 32'h3);
        repeat (30) @(negedge clk_i);
        chk({31'h0, core_o}, 32'h0);
        rd_chk(32'h0008_0000);
        print_verdict();
    end
    initial
    begin
        #800_000;
        n_fail++;
        print_verdict();
    end
endmodule
